// ---- design/sfq_defs.vh ----
// constants for the quad read and page program command block
`ifndef SFQ_DEFS_VH
`define SFQ_DEFS_VH

`define SFQ_OP_QUAD_READ     8'heb
`define SFQ_OP_PAGE_WRITE    8'h02
`define SFQ_OP_QUAD_PAGE     8'h32
`define SFQ_OP_CFG_WRITE     8'hc0
`define SFQ_EXIT_BYTE        8'hff

`define SFQ_ADDR_BYTES       2'h3
`define SFQ_DUMMY_CLKS       3'h4
`define SFQ_PAGE_BYTES       9'h100

`define SFQ_CFG_DRIVE_RST    2'h0
`define SFQ_CFG_DUMMY_RST    2'h0
`define SFQ_CFG_DRIVE_LSB    0
`define SFQ_CFG_DUMMY_LSB    2

`define SFQ_PROG_CYCLES      16'h07d0

`endif

// ---- design/sfq_sync.v ----
// two flip-flop synchroniser for pins from outside the sys_clk domain
module sfq_sync #(
    parameter WIDTH = 1
) (
    input  wire             sys_clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;

    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1   <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // sfq_sync

// ---- design/sfq_core.v ----
// quad read, config byte write and page program command sequencer
`include "sfq_defs.vh"

module sfq_core #(
    parameter [15:0] PROG_CYCLES = `SFQ_PROG_CYCLES
) (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        spi_clk,
    input  wire        spi_cs_n,
    input  wire [3:0]  dq_in,
    output reg  [3:0]  dq_out,
    output reg  [3:0]  dq_oe,
    input  wire        quad_peripheral_mode,
    input  wire        write_permit_latch,
    input  wire        pin_function_disable_bit,
    input  wire [3:0]  protect_region_bits,
    input  wire        other_cycle_busy,
    input  wire [7:0]  rd_data,
    output reg  [23:0] rd_addr,
    output reg         pgm_we,
    output reg  [23:0] pgm_addr,
    output reg  [7:0]  pgm_data,
    output reg         write_busy_flag,
    output reg         permit_clear,
    output reg  [1:0]  cfg_drive,
    output reg  [1:0]  cfg_dummy,
    output reg         cont_mode
);

    localparam S_CMD    = 3'h0;
    localparam S_ADDR   = 3'h1;
    localparam S_MODE   = 3'h2;
    localparam S_DUMMY  = 3'h3;
    localparam S_READ   = 3'h4;
    localparam S_PADDR  = 3'h5;
    localparam S_PDATA  = 3'h6;
    localparam S_IGNORE = 3'h7;

    wire [5:0] pins_sync;
    wire       s_clk  = pins_sync[5];
    wire       s_cs_n = ~pins_sync[4];
    wire [3:0] s_dq   = pins_sync[3:0];

    sfq_sync #(
        .WIDTH    (6)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({spi_clk, ~spi_cs_n, dq_in}),  // inverted so reset reads as deselected
        .sync_out (pins_sync)
    );

    reg  [2:0]   state;
    reg          prev_clk;
    reg          prev_cs_n;
    reg          wide;
    reg          is_cfg;
    reg  [2:0]   bitcnt;
    reg  [7:0]   sh;
    reg  [1:0]   addr_cnt;
    reg  [23:0]  addr;
    reg  [7:0]   first_byte;
    reg  [2:0]   dum_cnt;
    reg          nib_lo;
    reg  [23:0]  pp_addr;
    reg  [7:0]   pos;
    reg          got_byte;
    reg  [7:0]   page_buf [0:255];
    reg  [255:0] written;
    reg          draining;
    reg  [7:0]   drain_idx;
    reg          timing;
    reg  [15:0]  timer;

    wire clk_rise = s_clk & ~prev_clk & ~s_cs_n;
    wire clk_fall = ~s_clk & prev_clk & ~s_cs_n;
    wire cs_fall  = ~s_cs_n & prev_cs_n;
    wire cs_rise  = s_cs_n & ~prev_cs_n;
    wire busy_any = write_busy_flag | other_cycle_busy;

    // one or four bits per clock
    wire       step4     = wide | quad_peripheral_mode;
    wire [7:0] next_sh   = step4 ? {sh[3:0], s_dq} : {sh[6:0], s_dq[0]};
    wire       byte_done = step4 ? bitcnt[2] : (bitcnt == 3'h7);

    // protected area grows from the top in 64 KB blocks
    wire [8:0] prot_cnt = (protect_region_bits == 4'h0) ? 9'h000 :
                          (protect_region_bits >= 4'h9) ? `SFQ_PAGE_BYTES :
                          (9'h001 << (protect_region_bits - 4'h1));
    wire       page_protected = ({1'b0, pp_addr[23:16]} >= (`SFQ_PAGE_BYTES - prot_cnt));

    // a deselect that lands mid-byte leaves a partial byte in bitcnt
    wire pp_commit = (state == S_PDATA) & got_byte & (bitcnt == 3'h0)
                     & ~page_protected;

    always @(posedge sys_clk)
    begin
        if (clk_rise && state == S_PDATA && byte_done)
            page_buf[pos] <= next_sh;
    end

    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state      <= S_CMD;
            prev_clk   <= 1'b0;
            prev_cs_n  <= 1'b1;
            wide       <= 1'b0;
            is_cfg     <= 1'b0;
            bitcnt     <= 3'h0;
            sh         <= 8'h00;
            addr_cnt   <= 2'h0;
            addr       <= 24'h000000;
            first_byte <= 8'h00;
            dum_cnt    <= 3'h0;
            nib_lo     <= 1'b0;
            pp_addr    <= 24'h000000;
            pos        <= 8'h00;
            got_byte   <= 1'b0;
            written    <= 256'h0;
            rd_addr    <= 24'h000000;
            dq_out     <= 4'h0;
            dq_oe      <= 4'h0;
            cfg_drive  <= `SFQ_CFG_DRIVE_RST;
            cfg_dummy  <= `SFQ_CFG_DUMMY_RST;
            cont_mode  <= 1'b0;
        end
        else
        begin
            prev_clk  <= s_clk;
            prev_cs_n <= s_cs_n;
            if (cs_rise)
            begin
                dq_oe <= 4'h0;
                // a short all-ones transaction while skipping opcodes
                if (cont_mode && state == S_ADDR && addr_cnt <= 2'h1
                    && (addr_cnt == 2'h0 ? (bitcnt == 3'h0 || sh == `SFQ_EXIT_BYTE)
                                         : first_byte == `SFQ_EXIT_BYTE))
                    cont_mode <= 1'b0;
                state <= S_IGNORE;
            end
            else if (cs_fall)
            begin
                bitcnt   <= 3'h0;
                addr_cnt <= 2'h0;
                dum_cnt  <= 3'h0;
                nib_lo   <= 1'b0;
                is_cfg   <= 1'b0;
                if (cont_mode && !busy_any)
                begin
                    state <= S_ADDR;
                    wide  <= 1'b1;
                end
                else
                begin
                    state <= S_CMD;
                    wide  <= 1'b0;
                end
            end
            else if (clk_rise && state != S_READ && state != S_IGNORE)
            begin
                if (state == S_DUMMY)
                begin
                    dum_cnt <= dum_cnt + 3'h1;
                    if (dum_cnt == `SFQ_DUMMY_CLKS - 3'h1)
                    begin
                        state   <= S_READ;
                        rd_addr <= addr;
                    end
                end
                else
                begin
                    sh     <= next_sh;
                    bitcnt <= step4 ? bitcnt + 3'h4 : bitcnt + 3'h1;
                end
                if (state != S_DUMMY && byte_done)
                begin
                    case (state)
                        S_CMD:
                        begin
                            if (is_cfg)
                            begin
                                cfg_drive <= next_sh[`SFQ_CFG_DRIVE_LSB +: 2];
                                cfg_dummy <= next_sh[`SFQ_CFG_DUMMY_LSB +: 2];
                                state     <= S_IGNORE;
                            end
                            else if (next_sh == `SFQ_OP_QUAD_READ)
                            begin
                                state <= busy_any ? S_IGNORE : S_ADDR;
                                wide  <= 1'b1;
                            end
                            else if (next_sh == `SFQ_OP_PAGE_WRITE
                                     && write_permit_latch && !busy_any)
                            begin
                                state   <= S_PADDR;
                                written <= 256'h0;
                            end
                            else if (next_sh == `SFQ_OP_QUAD_PAGE && write_permit_latch
                                     && pin_function_disable_bit && !busy_any)
                            begin
                                state   <= S_PADDR;
                                wide    <= 1'b1;
                                written <= 256'h0;
                            end
                            else if (next_sh == `SFQ_OP_CFG_WRITE)
                                is_cfg <= 1'b1;
                            else
                                state <= S_IGNORE;
                        end
                        S_ADDR:
                        begin
                            addr     <= {addr[15:0], next_sh};
                            addr_cnt <= addr_cnt + 2'h1;
                            if (addr_cnt == 2'h0)
                                first_byte <= next_sh;
                            if (addr_cnt == `SFQ_ADDR_BYTES - 2'h1)
                                state <= S_MODE;
                        end
                        S_MODE:
                        begin
                            cont_mode <= (next_sh[7:4] == ~next_sh[3:0]);
                            state     <= S_DUMMY;
                        end
                        S_PADDR:
                        begin
                            pp_addr  <= {pp_addr[15:0], next_sh};
                            addr_cnt <= addr_cnt + 2'h1;
                            if (addr_cnt == `SFQ_ADDR_BYTES - 2'h1)
                            begin
                                state    <= S_PDATA;
                                pos      <= next_sh;
                                got_byte <= 1'b0;
                            end
                        end
                        S_PDATA:
                        begin
                            written[pos] <= 1'b1;
                            pos          <= pos + 8'h01;
                            got_byte     <= 1'b1;
                        end
                        default:
                            state <= S_IGNORE;
                    endcase
                end
            end
            else if (clk_fall && state == S_READ)
            begin
                dq_oe  <= 4'hf;
                dq_out <= nib_lo ? rd_data[3:0] : rd_data[7:4];
                nib_lo <= ~nib_lo;
                if (nib_lo)
                    rd_addr <= rd_addr + 24'h000001;
            end
            if (draining)
                written[drain_idx] <= 1'b0;
        end
    end

    // self-timed cycle: hand the marked bytes out, then hold busy for the program time
    always @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            draining        <= 1'b0;
            drain_idx       <= 8'h00;
            timing          <= 1'b0;
            timer           <= 16'h0000;
            pgm_we          <= 1'b0;
            pgm_addr        <= 24'h000000;
            pgm_data        <= 8'h00;
            write_busy_flag <= 1'b0;
            permit_clear    <= 1'b0;
        end
        else
        begin
            permit_clear <= 1'b0;
            pgm_we       <= 1'b0;
            if (cs_rise && pp_commit)
            begin
                draining        <= 1'b1;
                drain_idx       <= 8'h00;
                write_busy_flag <= 1'b1;
                permit_clear    <= 1'b1;
            end
            else if (draining)
            begin
                pgm_we    <= written[drain_idx];
                pgm_addr  <= {pp_addr[23:8], drain_idx};
                pgm_data  <= page_buf[drain_idx];
                drain_idx <= drain_idx + 8'h01;
                if (drain_idx == 8'hff)
                begin
                    draining <= 1'b0;
                    timing   <= 1'b1;
                    timer    <= 16'h0000;
                end
            end
            else if (timing)
            begin
                timer <= timer + 16'h0001;
                if (timer >= PROG_CYCLES - 16'h0001)
                begin
                    timing          <= 1'b0;
                    write_busy_flag <= 1'b0;
                end
            end
        end
    end

endmodule // sfq_core

// ---- verif/sfq_asserts.sv ----
// concurrent checks on the sequencer ports
module sfq_asserts #(
    parameter [15:0] PROG_CYCLES = 16'h07d0
) (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        spi_cs_n,
    input wire logic [3:0]  dq_oe,
    input wire logic        pgm_we,
    input wire logic [23:0] pgm_addr,
    input wire logic        write_busy_flag,
    input wire logic        permit_clear,
    input wire logic [1:0]  cfg_drive,
    input wire logic [1:0]  cfg_dummy
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_clr;
        permit_clear ##1 !permit_clear;
    endsequence
    property p_cfg_rst;
        $rose(rst_n) |-> cfg_drive == 2'h0 && cfg_dummy == 2'h0;
    endproperty
    property p_oe_idle;
        spi_cs_n [*5] |-> dq_oe == 4'h0;
    endproperty
    property p_oe_all;
        dq_oe == 4'h0 || dq_oe == 4'hf;
    endproperty
    property p_busy_quiet;
        write_busy_flag |-> dq_oe == 4'h0;
    endproperty
    property p_clr;
        permit_clear |-> s_clr ##[0:1] write_busy_flag;
    endproperty
    property p_we_busy;
        pgm_we |-> write_busy_flag;
    endproperty
    property p_page;
        pgm_we && $past(pgm_we) |-> pgm_addr[23:8] == $past(pgm_addr[23:8]);
    endproperty
    property p_busy_hold;
        $rose(write_busy_flag) |=> write_busy_flag [*8];
    endproperty
    a_cfg_rst: assert property (p_cfg_rst) else $error("config not cleared");
    a_oe_idle: assert property (p_oe_idle) else $error("drive after deselect");
    a_oe_all: assert property (p_oe_all) else $error("partial drive");
    a_busy_quiet: assert property (p_busy_quiet) else $error("read while busy");
    a_clr: assert property (p_clr) else $error("clear pulse bad");
    a_we_busy: assert property (p_we_busy) else $error("write while idle");
    a_page: assert property (p_page) else $error("page changed");
    a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
endmodule // sfq_asserts

bind sfq_core sfq_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n), .dq_oe(dq_oe),
    .pgm_we(pgm_we), .pgm_addr(pgm_addr), .write_busy_flag(write_busy_flag),
    .permit_clear(permit_clear), .cfg_drive(cfg_drive), .cfg_dummy(cfg_dummy));

// ---- verif/sfq_host.sv ----
// host controller model driving the serial link pins
module sfq_host (
    input  wire logic       sys_clk,
    input  wire logic [3:0] dq_out,
    output logic            spi_clk,
    output logic            spi_cs_n,
    output logic      [3:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] nib;
    initial
    begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        dq_in = 4'h0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // released lines toggle so a stale level is never mistaken for data
    task automatic tick(input logic [3:0] d, input logic drv);
        dq_in <= drv ? d : ~dq_in;
        wt(4);
        spi_clk <= 1'b1;
        nib = dq_out;
        wt(4);
        spi_clk <= 1'b0;
    endtask
    task automatic sel();
        spi_cs_n <= 1'b0;
        wt(4);
    endtask
    task automatic desel();
        wt(4);
        spi_cs_n <= 1'b1;
        wt(8);
    endtask
    task automatic send(input logic [7:0] b, input logic q);
        if (q)
        begin
            tick(b[7:4], 1'b1);
            tick(b[3:0], 1'b1);
        end
        else
            for (int i = 7; i >= 0; i--)
                tick({3'h0, b[i]}, 1'b1);
    endtask
    task automatic recv(output logic [7:0] b);
        tick(4'h0, 1'b0);
        b[7:4] = nib;
        tick(4'h0, 1'b0);
        b[3:0] = nib;
    endtask
endmodule // sfq_host

// ---- verif/sfq_core_tb.sv ----
// self-checking bench for the quad read and page program sequencer
module sfq_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        spi_clk, spi_cs_n;
    logic [3:0]  host_dq, dq_in, dq_out, dq_oe;
    logic        write_permit_latch = 1'b0;
    logic        permit_set = 1'b0;
    logic        quad_peripheral_mode = 1'b0;
    logic        pin_function_disable_bit = 1'b0;
    logic [3:0]  protect_region_bits = 4'h0;
    logic        other_cycle_busy = 1'b0;
    logic [7:0]  rd_data, pgm_data;
    logic [23:0] rd_addr, pgm_addr;
    logic        pgm_we, write_busy_flag, permit_clear, cont_mode;
    logic [1:0]  cfg_drive, cfg_dummy;
    logic [7:0]  wmem [256];
    logic [15:0] wpage;
    int          wr_cnt, wr_base, oe_cnt, oe_base, error_cnt, n_checks;
    always #20 sys_clk = ~sys_clk;
    // a sum, so the top address and zero give different bytes
    assign rd_data = rd_addr[7:0] + rd_addr[23:16];
    assign dq_in = (dq_oe & dq_out) | (~dq_oe & host_dq);
    // host samples the shared lines, so a released bus shows its own toggling
    sfq_host host (.sys_clk(sys_clk), .dq_out(dq_in), .spi_clk(spi_clk),
        .spi_cs_n(spi_cs_n), .dq_in(host_dq));
    sfq_core #(.PROG_CYCLES(16'h0014)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
        .quad_peripheral_mode(quad_peripheral_mode),
        .write_permit_latch(write_permit_latch), .other_cycle_busy(other_cycle_busy),
        .pin_function_disable_bit(pin_function_disable_bit),
        .protect_region_bits(protect_region_bits), .rd_data(rd_data),
        .rd_addr(rd_addr), .pgm_we(pgm_we), .pgm_addr(pgm_addr), .pgm_data(pgm_data),
        .write_busy_flag(write_busy_flag), .permit_clear(permit_clear),
        .cfg_drive(cfg_drive), .cfg_dummy(cfg_dummy), .cont_mode(cont_mode));
    // stands in for the array and the status logic
    always @(posedge sys_clk)
    begin
        if (pgm_we)
        begin
            wmem[pgm_addr[7:0]] <= pgm_data;
            wpage <= pgm_addr[23:8];
            wr_cnt <= wr_cnt + 1;
        end
        if (permit_clear)
            write_permit_latch <= 1'b0;
        else if (permit_set)
            write_permit_latch <= 1'b1;
        if (dq_oe !== 4'h0)
            oe_cnt <= oe_cnt + 1;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        while (write_busy_flag !== 1'b0 && k < 4000)
        begin
            @(posedge sys_clk);
            k++;
        end
        if (k == 4000)
        begin
            error_cnt++;
            wrap_up();
        end
    endtask
    // stands in for the write permit command of the status logic
    task automatic write_permit_command();
        permit_set <= 1'b1;
        @(posedge sys_clk);
        permit_set <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic qread(input logic op, input logic [23:0] a, input logic [7:0] m,
                         input int n);
        logic [7:0]  b;
        logic [7:0]  e;
        logic [23:0] x;
        host.sel();
        if (op)
            host.send(8'heb, 1'b0);
        for (int i = 0; i < 3; i++)
            host.send(a[23-8*i -: 8], 1'b1);
        host.send(m, 1'b1);
        repeat (4) host.tick(4'h0, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            host.recv(b);
            x = a + i;
            e = x[7:0] + x[23:16];
            if (!(other_cycle_busy | write_busy_flag))
                chk(b, e);
        end
        host.desel();
    endtask
    // data bytes past the 256th carry the inverted pattern
    task automatic prog(input logic [7:0] op, input logic [23:0] a, input int n,
                        input int extra, input logic q);
        wr_base = wr_cnt;
        host.sel();
        host.send(op, 1'b0);
        for (int i = 0; i < 3; i++)
            host.send(a[23-8*i -: 8], q);
        for (int i = 0; i < n; i++)
            host.send(i < 256 ? 8'h3c : 8'hc3, q);
        repeat (extra) host.tick(4'h1, 1'b1);
        host.desel();
    endtask
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk({cfg_drive, cfg_dummy}, 4'h0);
        prog(8'hc0, 24'h0d0000, 0, 0, 1'b0);
        chk({cfg_drive, cfg_dummy}, 4'h7);
        // a reset in mid-run must bring the config fields back as well
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk({cfg_drive, cfg_dummy}, 4'h0);
        quad_peripheral_mode <= 1'b1;
        host.sel();
        host.send(8'hc0, 1'b1);
        host.send(8'h06, 1'b1);
        host.desel();
        quad_peripheral_mode <= 1'b0;
        chk({cfg_drive, cfg_dummy}, 4'h9);
        qread(1'b1, 24'hffffff, 8'ha5, 2);
        chk(cont_mode, 1'b1);
        qread(1'b0, 24'h000010, 8'h55, 1);
        chk(cont_mode, 1'b0);
        qread(1'b1, 24'h123456, 8'h0f, 3);
        chk(cont_mode, 1'b1);
        host.sel();
        host.send(8'hff, 1'b1);
        host.desel();
        chk(cont_mode, 1'b0);
        qread(1'b1, 24'h00abcd, 8'h00, 2);
        oe_base = oe_cnt;
        other_cycle_busy <= 1'b1;
        qread(1'b1, 24'h000040, 8'h00, 2);
        other_cycle_busy <= 1'b0;
        chk(oe_cnt - oe_base, 0);
        write_permit_command();
        prog(8'h02, 24'h0100fe, 3, 0, 1'b0);
        chk(write_busy_flag, 1'b1);
        chk(write_permit_latch, 1'b0);
        qread(1'b1, 24'h000040, 8'h00, 2);
        wait_idle();
        chk(oe_cnt - oe_base, 0);
        chk(wr_cnt - wr_base, 3);
        chk({wpage, wmem[8'hfe], wmem[8'h00]}, {16'h0100, 16'h3c3c});
        prog(8'h02, 24'h000010, 1, 0, 1'b0);
        chk(write_busy_flag, 1'b0);
        write_permit_command();
        protect_region_bits <= 4'h1;
        prog(8'h02, 24'hff0000, 1, 0, 1'b0);
        chk(write_busy_flag, 1'b0);
        protect_region_bits <= 4'h0;
        prog(8'h02, 24'h000010, 1, 3, 1'b0);
        chk(write_busy_flag, 1'b0);
        prog(8'h32, 24'h000203, 1, 0, 1'b1);
        chk(write_busy_flag, 1'b0);
        pin_function_disable_bit <= 1'b1;
        prog(8'h32, 24'h000203, 1, 0, 1'b1);
        wait_idle();
        chk(wr_cnt - wr_base, 1);
        chk(wmem[8'h03], 8'h3c);
        write_permit_command();
        prog(8'h02, 24'h000200, 258, 0, 1'b0);
        wait_idle();
        chk(wr_cnt - wr_base, 256);
        chk({wmem[8'h01], wmem[8'h02]}, 16'hc33c);
        wrap_up();
    end
endmodule // sfq_core_tb
